/* File: pkg/rdo_pkg.sv */
// Constants shared by the resolver data output block.
// Assumes a 20 MHz reference clock and a 12-bit tracking loop word.
package rdo_pkg;
   localparam int unsigned DATA_W        = 12;
   localparam int unsigned SER_W         = 16;
   localparam int unsigned FIFO_DEPTH    = 32;
   localparam int unsigned FIFO_W        = 2 * DATA_W + 2;
   // Serial word field positions
   localparam int unsigned SER_DATA_LSB  = 4;
   localparam int unsigned SER_SEL_BIT   = 3;
   localparam int unsigned SER_DEG_BIT   = 2;
   localparam int unsigned SER_LOST_BIT  = 1;
   localparam int unsigned SER_PAR_BIT   = 0;
   // FIFO word field positions
   localparam int unsigned FW_POS_LSB    = 0;
   localparam int unsigned FW_VEL_LSB    = DATA_W;
   localparam int unsigned FW_DEG_BIT    = 2 * DATA_W;
   localparam int unsigned FW_LOST_BIT   = 2 * DATA_W + 1;
   // Reset values
   localparam logic [DATA_W-1:0] POS_RST = 12'h000;
   localparam logic [DATA_W-1:0] VEL_RST = 12'h000;
   localparam logic [5:0]        SYNC_RST = 6'h3f;
   // Pin sync vector positions
   localparam int unsigned SY_SAMPLE = 0;
   localparam int unsigned SY_RD     = 1;
   localparam int unsigned SY_CS     = 2;
   localparam int unsigned SY_PSEL   = 3;
   localparam int unsigned SY_SMODE  = 4;
   localparam int unsigned SY_SCLK   = 5;
   // Bus line roles in serial mode
   localparam int unsigned LINE_SOUT = 11;
   localparam int unsigned LINE_SCLK = 10;
   localparam logic [DATA_W-1:0] OE_SERIAL   = 12'h800;
   localparam logic [DATA_W-1:0] OE_PARALLEL = 12'hfff;
   // Encoder update tick derived from the clock rates
   localparam longint unsigned REF_CLK_HZ = 20_000_000;
   localparam longint unsigned UPDATE_HZ  = 4_096_000;
   localparam int unsigned     ACC_W      = 16;
   localparam logic [ACC_W-1:0] TICK_INC  =
      ACC_W'((UPDATE_HZ << ACC_W) / REF_CLK_HZ);
endpackage

/* File: pkg/rdo_fifo_if.sv */
// Valid/ready stream between the output block and its sample FIFO.
// Assumes one clock for both sides.
`timescale 1ns/1ps
interface rdo_fifo_if #(parameter int unsigned W = 8);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   modport user (output in_valid, in_data, out_ready,
                 input  in_ready, out_valid, out_data);
   modport fifo (input  in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
endinterface

/* File: rtl/rdo_fifo.sv */
// Synchronous FIFO for latched samples.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps
module rdo_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   rdo_fifo_if.fifo  s
);
   localparam int unsigned AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("rdo_fifo depth must be a power of two");
      end
   endgenerate
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   wire          full  = (wr_q[AW] != rd_q[AW]) &&
                         (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire          empty = (wr_q == rd_q);
   wire          push  = s.in_valid && !full;
   wire          pop   = s.out_ready && !empty;
   assign s.in_ready  = !full;
   assign s.out_valid = !empty;
   assign s.out_data  = mem[rd_q[AW-1:0]];
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= s.in_data;
      end
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= push ? wr_q + 1'b1 : wr_q;
         rd_q <= pop ? rd_q + 1'b1 : rd_q;
      end
   end
endmodule

/* File: rtl/rdo_encoder.sv */
// Incremental encoder emulation from the tracking angle.
// Assumes a one-cycle update tick and an angle on the same clock.
`timescale 1ns/1ps
module rdo_encoder
   import rdo_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         tick,
   input  wire logic [W-1:0] angle,
   output logic              quad_a,
   output logic              quad_b,
   output logic              index_marker_pulse,
   output logic              direction
);
   generate
      if (W < 3) begin : g_chk
         $error("rdo_encoder needs at least 3 angle bits");
      end
   endgenerate
   logic [W-1:0] count_q;
   wire  [W-1:0] diff   = angle - count_q;
   wire          moving = (diff != '0);
   wire          up     = !diff[W-1];
   wire  [W-1:0] count_d = up ? count_q + 1'b1 : count_q - 1'b1;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         count_q            <= POS_RST;
         quad_a             <= 1'b0;
         quad_b             <= 1'b0;
         index_marker_pulse <= 1'b0;
         direction          <= 1'b1;
      end else if (tick && moving) begin
         count_q            <= count_d;
         quad_a             <= count_d[1] ^ count_d[0];
         quad_b             <= count_d[1];
         index_marker_pulse <= (count_d == '0);
         direction          <= up;
      end
   end
endmodule

/* File: rtl/rdo_output_ports.sv */
// Resolver data output ports: holding registers, parallel and serial
// read, encoder emulation.
// Assumes the tracking loop words and fault flags arrive on ref_clk;
// all host pins are asynchronous and pass two flip-flops.
// Operation
// - Bus floats; drives only while select and read low
// - Read fall copies selected register to buffer
// - Read high releases bus to float
// - Sample fall latches position and velocity
// - Tracking runs on; only holding registers frozen
// - Select high position, low velocity, before read
// - Serial: line 11 out, line 10 clock
// - Sixteen-bit shift register, bit 15 first
// - Word: data, select bit, degraded, lost flags
// - Bit 0 makes word parity odd
// - Position unsigned, velocity twos complement
// - MSB ready first; later bits on rises
// - Extra clocks past word shift out zeros
// - 1024 quadrature pulses, A leads when increasing
// - Direction high for increasing angle
// - Index marker one quarter A cycle at zero
// - Encoder updated at 4.096 MHz, four per pulse
// - Serial mode input high selects parallel port
// - Reset zeroes position, clears both fault flags
`timescale 1ns/1ps
module rdo_output_ports
   import rdo_pkg::*;
#(
   parameter int unsigned W     = DATA_W,
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] position_in,
   input  wire logic [W-1:0] velocity_in,
   input  wire logic         degraded_in,
   input  wire logic         lost_in,
   input  wire logic         sample_n,
   input  wire logic         read_n,
   input  wire logic         chip_select_n,
   input  wire logic         position_select,
   input  wire logic         serial_mode_n,
   input  wire logic [W-1:0] bus_in,
   output logic [W-1:0]      bus_out,
   output logic [W-1:0]      bus_oe,
   output logic              signal_degraded_flag,
   output logic              tracking_lost_flag,
   output logic              quad_a,
   output logic              quad_b,
   output logic              index_marker_pulse,
   output logic              direction
);
   generate
      if (W != DATA_W) begin : g_chk
         $error("rdo_output_ports supports a 12-bit word only");
      end
   endgenerate

   // Pin synchronisers
   wire  [5:0] pins_raw = {bus_in[LINE_SCLK], serial_mode_n,
                           position_select, chip_select_n,
                           read_n, sample_n};
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   logic [5:0] sync3_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         sync3_q <= SYNC_RST;
      end else begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   wire sample_fall = sync3_q[SY_SAMPLE] && !sync2_q[SY_SAMPLE];
   wire rd_low      = !sync2_q[SY_RD];
   wire rd_fall     = sync3_q[SY_RD] && rd_low;
   wire cs_low      = !sync2_q[SY_CS];
   wire psel        = sync2_q[SY_PSEL];
   wire serial_mode = !sync2_q[SY_SMODE];
   wire sclk_rise   = !sync3_q[SY_SCLK] && sync2_q[SY_SCLK];
   wire read_active = rd_low && cs_low;
   wire read_begin  = rd_fall && cs_low;

   // Sample FIFO in the data path
   rdo_fifo_if #(.W(FIFO_W)) fq ();

   rdo_fifo #(
      .W     (FIFO_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .ref_clk (ref_clk),
      .rst     (rst),
      .s       (fq.fifo)
   );

   // Capture straight from the running integrators
   assign fq.in_valid = sample_fall;
   assign fq.in_data  = {lost_in, degraded_in,
                         velocity_in, position_in};
   // Holding registers frozen while a read is in progress
   assign fq.out_ready = !read_active;

   logic [W-1:0] pos_hold_q;
   logic [W-1:0] vel_hold_q;
   logic         deg_hold_q;
   logic         lost_hold_q;
   wire          hold_load = fq.out_valid && fq.out_ready;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pos_hold_q  <= POS_RST;
         vel_hold_q  <= VEL_RST;
         deg_hold_q  <= 1'b0;
         lost_hold_q <= 1'b0;
      end else if (hold_load) begin
         pos_hold_q  <= fq.out_data[FW_POS_LSB +: W];
         vel_hold_q  <= fq.out_data[FW_VEL_LSB +: W];
         deg_hold_q  <= fq.out_data[FW_DEG_BIT];
         lost_hold_q <= fq.out_data[FW_LOST_BIT];
      end
   end

   // Word selection; both formats pass through unchanged
   wire [W-1:0] sel_word = psel ? pos_hold_q : vel_hold_q;
   wire [SER_W-1:0] ser_body;
   assign ser_body[SER_W-1:SER_DATA_LSB] = sel_word;
   assign ser_body[SER_SEL_BIT]          = psel;
   assign ser_body[SER_DEG_BIT]          = deg_hold_q;
   assign ser_body[SER_LOST_BIT]         = lost_hold_q;
   assign ser_body[SER_PAR_BIT]          = 1'b0;
   wire odd_check_bit = ~^ser_body[SER_W-1:1];
   wire [SER_W-1:0] ser_word = {ser_body[SER_W-1:1], odd_check_bit};

   // Parallel output buffer
   logic [W-1:0] par_buf_q;
   wire  [W-1:0] par_buf_d = (read_begin && !serial_mode) ?
                             sel_word : par_buf_q;

   // Serial shift register; load at read start, MSB ready at once
   logic [SER_W-1:0] shift_q;
   wire              ser_load  = read_begin && serial_mode;
   wire              ser_shift = read_active && serial_mode &&
                                 sclk_rise && !rd_fall;
   wire [SER_W-1:0]  shift_d   = ser_load  ? ser_word :
                                 ser_shift ? {shift_q[SER_W-2:0],
                                              1'b0} :
                                 shift_q;

   // Pin drive
   wire [W-1:0] ser_pins = {shift_d[SER_W-1], {(W-1){1'b0}}};
   wire [W-1:0] bus_d    = serial_mode ? ser_pins : par_buf_d;
   wire [W-1:0] oe_mode  = serial_mode ? OE_SERIAL :
                                         OE_PARALLEL;
   wire [W-1:0] oe_d     = read_active ? oe_mode : '0;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         par_buf_q <= POS_RST;
         shift_q   <= '0;
         bus_out   <= POS_RST;
         bus_oe    <= '0;
      end else begin
         par_buf_q <= par_buf_d;
         shift_q   <= shift_d;
         bus_out   <= bus_d;
         bus_oe    <= oe_d;
      end
   end

   // Fault flag pins follow the holding registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         signal_degraded_flag <= 1'b0;
         tracking_lost_flag   <= 1'b0;
      end else begin
         signal_degraded_flag <= deg_hold_q;
         tracking_lost_flag   <= lost_hold_q;
      end
   end

   // Encoder update tick by phase accumulation
   logic [ACC_W-1:0] acc_q;
   logic             tick_q;
   wire  [ACC_W:0]   acc_sum = {1'b0, acc_q} + {1'b0, TICK_INC};

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acc_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         acc_q  <= acc_sum[ACC_W-1:0];
         tick_q <= acc_sum[ACC_W];
      end
   end

   // Encoder runs from the live angle, not the held one
   rdo_encoder #(
      .W (W)
   ) u_encoder (
      .ref_clk            (ref_clk),
      .rst                (rst),
      .tick               (tick_q),
      .angle              (position_in),
      .quad_a             (quad_a),
      .quad_b             (quad_b),
      .index_marker_pulse (index_marker_pulse),
      .direction          (direction)
   );
endmodule

/* File: sim/rdo_chk.sv */
// Port checker for the resolver data output block.
// Assumes a bind to the top module; sees its ports only.
`timescale 1ns/1ps
module rdo_chk #(
   parameter int unsigned W = 12
) (
   input wire logic         ref_clk,
   input wire logic         rst,
   input wire logic         sample_n,
   input wire logic         read_n,
   input wire logic         chip_select_n,
   input wire logic         serial_mode_n,
   input wire logic [W-1:0] bus_out,
   input wire logic [W-1:0] bus_oe,
   input wire logic         signal_degraded_flag,
   input wire logic         tracking_lost_flag,
   input wire logic         quad_a,
   input wire logic         quad_b,
   input wire logic         index_marker_pulse,
   input wire logic         direction
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence quad_move;
      $changed(quad_a) || $changed(quad_b);
   endsequence
   sequence quad_quiet;
      (!$changed(quad_a) && !$changed(quad_b)) [*3];
   endsequence
   AST_READ_OFF: assert property (read_n [*5] |-> bus_oe == '0)
      else $error("bus driven after read ended");
   AST_CS_OFF: assert property (chip_select_n [*5] |-> bus_oe == '0)
      else $error("bus driven without chip select");
   AST_OE_MODE: assert property (bus_oe != '0 |->
      bus_oe == (serial_mode_n ? 12'hfff : 12'h800))
      else $error("enable pattern wrong for mode");
   AST_SER_PINS: assert property (bus_oe == 12'h800 |->
      bus_out[10:0] == '0)
      else $error("low lines active in serial read");
   AST_PAR_HOLD: assert property (bus_oe == 12'hfff &&
      $past(bus_oe) == 12'hfff |-> $stable(bus_out))
      else $error("parallel word changed during read");
   AST_FLAG_HOLD: assert property ((sample_n && read_n) [*8] |->
      $stable({signal_degraded_flag, tracking_lost_flag}))
      else $error("flags changed without sample");
   AST_GRAY: assert property (!($changed(quad_a) && $changed(quad_b)))
      else $error("both quadrature lines moved");
   AST_RATE: assert property (quad_move |=> quad_quiet)
      else $error("quadrature updates too close");
   AST_DIR: assert property ($rose(quad_a) |-> direction == !quad_b)
      else $error("direction disagrees with phase");
   AST_INDEX: assert property (index_marker_pulse |->
      !quad_a && !quad_b)
      else $error("index outside zero state");
endmodule

/* File: sim/rdo_host.sv */
// Host model: sample, read, select and serial clock pins.
// Assumes the bench clock; pins change on its falling edge.
`timescale 1ns/1ps
module rdo_host (
   input  wire logic        ref_clk,
   input  wire logic [11:0] bus_out,
   input  wire logic [11:0] bus_oe,
   output logic             sample_n,
   output logic             read_n,
   output logic             chip_select_n,
   output logic             position_select,
   output logic             serial_mode_n,
   output logic             sclk
);
   initial begin
      sample_n = 1'b1;
      read_n = 1'b1;
      chip_select_n = 1'b1;
      position_select = 1'b1;
      serial_mode_n = 1'b1;
      sclk = 1'b1;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic sample();
      sample_n = 1'b0;
      cyc(6);
      sample_n = 1'b1;
      cyc(16);
   endtask
   task automatic pread(input logic sel, cs, smp,
                        output logic [11:0] d, oe);
      position_select = sel;
      chip_select_n = cs;
      cyc(1);
      read_n = 1'b0;
      cyc(8);
      if (smp)
         sample();
      d = bus_out;
      oe = bus_oe;
      read_n = 1'b1;
      cyc(6);
   endtask
   task automatic sread(input logic sel, output logic [16:0] w,
                        output logic [11:0] oe);
      serial_mode_n = 1'b0;
      position_select = sel;
      chip_select_n = 1'b0;
      cyc(4);
      read_n = 1'b0;
      cyc(8);
      oe = bus_oe;
      for (int i = 16; i >= 0; i--) begin
         sclk = 1'b0;
         cyc(4);
         w[i] = bus_out[11];
         sclk = 1'b1;
         cyc(4);
      end
      read_n = 1'b1;
      cyc(6);
   endtask
endmodule

/* File: sim/tb_top.sv */
// Bench top: clock, reset, host model, scenarios, verdict.
// Assumes package, design, checker and host model compiled first.
`timescale 1ns/1ps
module tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] position_in = 12'h000;
   logic [11:0] velocity_in = 12'h000;
   logic        degraded_in = 1'b0;
   logic        lost_in = 1'b0;
   logic        sample_n, read_n, chip_select_n;
   logic        position_select, serial_mode_n, sclk;
   logic [11:0] bus_in, bus_out, bus_oe;
   logic        signal_degraded_flag, tracking_lost_flag;
   logic        quad_a, quad_b, index_marker_pulse, direction;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc_cnt = 0;
   assign bus_in = (bus_oe & bus_out) |
                   (~bus_oe & {~bus_out[11], sclk, ~bus_out[9:0]});
   rdo_output_ports i_dut (.*);
   rdo_host i_host (.*);
   always #25 ref_clk = ~ref_clk;
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 3000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [16:0] e, g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h seen %h", n, e, g);
      end
   endtask
   task automatic t_reset();
      logic [11:0] d, oe;
      chk("oe", 17'h0, 17'(bus_oe));
      chk("dir idx", 17'h2, 17'({direction, index_marker_pulse}));
      chk("flags", 17'h0,
          17'({signal_degraded_flag, tracking_lost_flag}));
      i_host.pread(1'b1, 1'b0, 1'b0, d, oe);
      chk("pos", 17'h0, 17'(d));
      $display("test reset done");
   endtask
   task automatic t_enc();
      position_in = 12'h00a;
      repeat (80) @(negedge ref_clk);
      chk("dir up", 17'h1, 17'(direction));
      chk("quad up", 17'h3, 17'({quad_a, quad_b}));
      position_in = 12'h004;
      repeat (80) @(negedge ref_clk);
      chk("dir down", 17'h0, 17'(direction));
      chk("quad down", 17'h0, 17'({quad_a, quad_b}));
      position_in = 12'h000;
      repeat (40) @(negedge ref_clk);
      chk("index", 17'h1, 17'({quad_a, quad_b, index_marker_pulse}));
      $display("test encoder done");
   endtask
   task automatic t_par();
      logic [11:0] d, oe;
      position_in = 12'h9a5;
      velocity_in = 12'hf3c;
      degraded_in = 1'b1;
      i_host.sample();
      i_host.pread(1'b1, 1'b0, 1'b0, d, oe);
      chk("pos", 17'h09a5, 17'(d));
      chk("oe", 17'h0fff, 17'(oe));
      i_host.pread(1'b0, 1'b0, 1'b0, d, oe);
      chk("vel", 17'h0f3c, 17'(d));
      i_host.pread(1'b1, 1'b1, 1'b0, d, oe);
      chk("no cs", 17'h0, 17'(oe));
      chk("deg", 17'h1, 17'(signal_degraded_flag));
      position_in = 12'h5a6;
      i_host.pread(1'b1, 1'b0, 1'b1, d, oe);
      chk("frozen", 17'h09a5, 17'(d));
      i_host.pread(1'b1, 1'b0, 1'b0, d, oe);
      chk("queued", 17'h05a6, 17'(d));
      $display("test parallel done");
   endtask
   task automatic t_rst2();
      logic [11:0] d, oe;
      rst = 1'b1;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      chk("rst flags", 17'h0,
          17'({signal_degraded_flag, tracking_lost_flag}));
      i_host.pread(1'b1, 1'b0, 1'b0, d, oe);
      chk("rst pos", 17'h0, 17'(d));
      $display("test mid reset done");
   endtask
   task automatic t_ser();
      logic [16:0] w;
      logic [15:0] e;
      logic [11:0] oe;
      degraded_in = 1'b0;
      lost_in = 1'b1;
      i_host.sample();
      chk("lost", 17'h1, 17'(tracking_lost_flag));
      for (int s = 1; s >= 0; s--) begin
         e = {s[0] ? position_in : velocity_in, s[0], 3'b010};
         e[0] = ~^e[15:1];
         i_host.sread(s[0], w, oe);
         chk("word", {e, 1'b0}, w);
         chk("oe", 17'h0800, 17'(oe));
      end
      $display("test serial done");
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      t_reset();
      t_enc();
      t_par();
      t_rst2();
      t_ser();
      stop_test();
   end
endmodule
bind rdo_output_ports rdo_chk #(.W(W)) i_chk (.*);
